// *** rtl/btag_top.sv ***
`timescale 1ns/1ps
module btag_top
   import btag_pkg::*;
(
   input  wire logic                    SYS_CLK,
   input  wire logic                    RST_N,
   input  wire btag_pkg::btag_req_t     REQ,
   output logic                         REQ_READY,
   input  wire logic [15:0]             ACCUM_PAIR,
   input  wire logic [15:0]             SECOND_PAIR,
   input  wire logic [15:0]             THIRD_PAIR,
   input  wire logic [15:0]             FOURTH_PAIR,
   input  wire logic                    BANK_WR,
   input  wire logic [7:0]              BANK_WDATA,
   output logic      [7:0]              BANK_RDATA,
   output btag_pkg::btag_mem_req_t      MEM_REQ,
   input  wire btag_pkg::btag_mem_rsp_t MEM_RSP,
   output logic                         PC_LOAD,
   output logic      [19:0]             PROGRAM_COUNTER,
   output logic                         BAD_REQ
);
   import btag_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW  = 2'b01,
      ST_HIGH = 2'b11
   } btag_state_t;

   btag_state_t  state;
   btag_state_t  next_state;
   logic [3:0]   code_bank;
   logic [7:0]   low_byte;
   logic [19:0]  tbl_addr;
   logic [15:0]  pair_val;

   btag_reg_sel u_sel (
      .accum_pair  (ACCUM_PAIR),
      .second_pair (SECOND_PAIR),
      .third_pair  (THIRD_PAIR),
      .fourth_pair (FOURTH_PAIR),
      .pair        (REQ.pair),
      .pair_val    (pair_val)
   );

   wire take = REQ.valid && (state == ST_IDLE);
   wire [19:0] disp8  = {{12{REQ.imm[7]}}, REQ.imm[7:0]};
   wire [19:0] disp16 = {{4{REQ.imm[15]}}, REQ.imm[15:0]};
   // Relative only for the branch class
   wire rel_ok = REQ.is_branch && !REQ.is_table_call;
   // Table mode only for the table call instruction
   wire tbl_ok = REQ.is_table_call;
   // Jump through a pair is legal only via the accumulator pair
   wire reg_ok = !REQ.is_jump || (REQ.pair == BTAG_ACCUM);
   wire is_rel = (REQ.mode == BTAG_REL8) || (REQ.mode == BTAG_REL16);
   wire illegal = (is_rel && !rel_ok) ||
                  ((REQ.mode == BTAG_TABLE) != tbl_ok) ||
                  ((REQ.mode == BTAG_REGDIR) && !reg_ok) ||
                  (REQ.mode == BTAG_NONE);
   wire [19:0] rel_tgt = REQ.next_pc + ((REQ.mode == BTAG_REL8) ? disp8 : disp16);
   wire [19:0] imm20_tgt = REQ.imm;
   wire [19:0] imm16_tgt = {UPPER_ZERO, REQ.imm[15:0]};
   // Bank supplies bits 19..16, pair the low half
   wire [19:0] reg_tgt = {code_bank, pair_val};
   wire [19:0] direct_tgt = is_rel ? rel_tgt :
                            (REQ.mode == BTAG_IMM20) ? imm20_tgt :
                            (REQ.mode == BTAG_IMM16) ? imm16_tgt : reg_tgt;
   wire start_tbl = take && !illegal && (REQ.mode == BTAG_TABLE);
   wire direct_done = take && !illegal && (REQ.mode != BTAG_TABLE);

   assign REQ_READY = (state == ST_IDLE);
   assign BANK_RDATA = {4'h0, code_bank};
   assign MEM_REQ.rd = (state != ST_IDLE);
   assign MEM_REQ.addr = (state == ST_HIGH) ? tbl_addr + 20'h00001 : tbl_addr;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_tbl) begin
               next_state = ST_LOW;
            end
         end
         ST_LOW: begin
            if (MEM_RSP.valid) begin
               next_state = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (MEM_RSP.valid) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         code_bank <= BANK_RST[3:0];
      end else if (BANK_WR) begin
         code_bank <= BANK_WDATA[3:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tbl_addr <= 20'h00000;
         low_byte <= 8'h00;
      end else begin
         if (start_tbl) begin
            tbl_addr <= btag_tbl_addr(REQ.tbl_idx);
         end
         if ((state == ST_LOW) && MEM_RSP.valid) begin
            low_byte <= MEM_RSP.data;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PC_LOAD <= 1'b0;
         PROGRAM_COUNTER <= 20'h00000;
         BAD_REQ <= 1'b0;
      end else begin
         PC_LOAD <= 1'b0;
         BAD_REQ <= take && illegal;
         if (direct_done) begin
            PC_LOAD <= 1'b1;
            PROGRAM_COUNTER <= direct_tgt;
         end else if ((state == ST_HIGH) && MEM_RSP.valid) begin
            PC_LOAD <= 1'b1;
            // Low byte first, upper nibble held at zero
            PROGRAM_COUNTER <= {UPPER_ZERO, MEM_RSP.data, low_byte};
         end
      end
   end

   // Accepted requests that load in one step
   sequence s_rel8_take;
      take && !illegal && REQ.mode == BTAG_REL8;
   endsequence
   sequence s_rel16_take;
      take && !illegal && REQ.mode == BTAG_REL16;
   endsequence
   sequence s_reg_take;
      take && !illegal && REQ.mode == BTAG_REGDIR;
   endsequence

   a_rel_target: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_rel8_take |=>
      PC_LOAD && PROGRAM_COUNTER == $past(REQ.next_pc) + {{12{$past(REQ.imm[7])}},
      $past(REQ.imm[7:0])}) else $error("relative target wrong");
   a_rel16_target: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_rel16_take |=>
      PC_LOAD && PROGRAM_COUNTER == $past(REQ.next_pc) + {{4{$past(REQ.imm[15])}},
      $past(REQ.imm[15:0])}) else $error("relative 16-bit target wrong");
   a_rel_class: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (take && is_rel && !REQ.is_branch) |=> !PC_LOAD && BAD_REQ)
      else $error("relative used outside branch");
   a_imm20_copy: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (take && !illegal && REQ.mode == BTAG_IMM20) |=> PROGRAM_COUNTER == $past(REQ.imm))
      else $error("imm20 not copied");
   a_imm16_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (take && !illegal && REQ.mode == BTAG_IMM16) |=>
      PROGRAM_COUNTER == {4'h0, $past(REQ.imm[15:0])})
      else $error("imm16 upper bits not zero");
   a_tbl_range: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      MEM_REQ.rd |-> MEM_REQ.addr >= TBL_BASE && MEM_REQ.addr <= TBL_LAST)
      else $error("table address out of area");
   // Table fetch steps: entry address, first byte, second byte
   sequence s_tbl_fetch;
      start_tbl ##1 (state == ST_LOW);
   endsequence
   sequence s_tbl_first;
      state == ST_LOW && MEM_RSP.valid;
   endsequence
   sequence s_tbl_second;
      state == ST_HIGH && MEM_RSP.valid;
   endsequence
   a_tbl_pair: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_tbl_fetch |-> MEM_REQ.rd && !PC_LOAD &&
      MEM_REQ.addr == TBL_BASE + {14'h0000, $past(REQ.tbl_idx), 1'b0})
      else $error("table entry address wrong");
   a_tbl_next: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_tbl_first |=> MEM_REQ.rd && MEM_REQ.addr == $past(MEM_REQ.addr) + 20'h00001)
      else $error("second table byte not at next address");
   a_tbl_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_tbl_first |=> low_byte == $past(MEM_RSP.data))
      else $error("first table byte not kept");
   a_tbl_order: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_tbl_second |=> PC_LOAD && PROGRAM_COUNTER[15:8] == $past(MEM_RSP.data) &&
      PROGRAM_COUNTER[7:0] == $past(low_byte))
      else $error("table bytes loaded in wrong order");
   a_tbl_only: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (take && REQ.mode == BTAG_TABLE && !REQ.is_table_call) |=> state == ST_IDLE && BAD_REQ)
      else $error("table mode outside table call");
   a_tbl_low64k: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ($past(state) == ST_HIGH && PC_LOAD) |-> PROGRAM_COUNTER[19:16] == 4'h0)
      else $error("table target above 64 KB");
   a_reg_direct: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_reg_take |=> PROGRAM_COUNTER == {$past(code_bank), $past(pair_val)})
      else $error("register direct target wrong");
   a_reg_bank: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_reg_take |=> PC_LOAD && PROGRAM_COUNTER[19:16] == $past(BANK_RDATA[3:0]))
      else $error("bank not in upper target bits");
   a_jump_accum: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (take && REQ.mode == BTAG_REGDIR && REQ.is_jump && REQ.pair != BTAG_ACCUM) |=> !PC_LOAD)
      else $error("jump via non-accumulator pair");
   a_bank_upper: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      BANK_WR |=> BANK_RDATA == {4'h0, $past(BANK_WDATA[3:0])})
      else $error("bank register readback wrong");
endmodule

// *** rtl/btag_pkg.sv ***
package btag_pkg;

   localparam int PC_W         = 20;
   localparam int TBL_IDX_W    = 5;
   localparam int BANK_W       = 4;
   // Table area base, entries are two bytes each
   localparam logic [19:0] TBL_BASE     = 20'h00080;
   localparam logic [19:0] TBL_LAST     = 20'h000bf;
   localparam logic [7:0]  BANK_RST     = 8'h00;
   localparam logic [3:0]  UPPER_ZERO   = 4'h0;

   typedef enum logic [2:0] {
      BTAG_NONE    = 3'h0,
      BTAG_REL8    = 3'h1,
      BTAG_REL16   = 3'h3,
      BTAG_IMM20   = 3'h2,
      BTAG_IMM16   = 3'h6,
      BTAG_TABLE   = 3'h7,
      BTAG_REGDIR  = 3'h5
   } btag_mode_t;

   typedef enum logic [1:0] {
      BTAG_ACCUM  = 2'h0,
      BTAG_SECOND = 2'h1,
      BTAG_THIRD  = 2'h2,
      BTAG_FOURTH = 2'h3
   } btag_pair_t;

   // One request from the decoder
   typedef struct packed {
      logic              valid;
      btag_mode_t        mode;
      logic              is_jump;      // Jump form, else call form
      logic              is_branch;    // Branch class instruction
      logic              is_table_call;
      logic [19:0]       next_pc;
      logic [19:0]       imm;
      logic [4:0]        tbl_idx;
      btag_pair_t        pair;
   } btag_req_t;

   // Table fetch handshake with fetch unit
   typedef struct packed {
      logic              rd;
      logic [19:0]       addr;
   } btag_mem_req_t;

   typedef struct packed {
      logic              valid;
      logic [7:0]        data;
   } btag_mem_rsp_t;

   function automatic logic [19:0] btag_tbl_addr(input logic [4:0] idx);
      btag_tbl_addr = TBL_BASE + {14'h0000, idx, 1'b0};
   endfunction

endpackage

// *** rtl/btag_reg_sel.sv ***
`timescale 1ns/1ps
module btag_reg_sel
   import btag_pkg::*;
(
   input  wire logic [15:0]          accum_pair,
   input  wire logic [15:0]          second_pair,
   input  wire logic [15:0]          third_pair,
   input  wire logic [15:0]          fourth_pair,
   input  wire btag_pkg::btag_pair_t pair,
   output logic      [15:0]          pair_val
);
   import btag_pkg::*;

   assign pair_val = (pair == BTAG_ACCUM)  ? accum_pair  :
                     (pair == BTAG_SECOND) ? second_pair :
                     (pair == BTAG_THIRD)  ? third_pair  : fourth_pair;
endmodule

// *** verif/btag_fetch_model.sv ***
`timescale 1ns/1ps
module btag_fetch_model
   import btag_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [3:0]            dly,
   input  wire btag_pkg::btag_mem_req_t mem_req,
   output btag_pkg::btag_mem_rsp_t    mem_rsp
);
   import btag_pkg::*;
   logic [3:0] wait_cnt;
   // Gap after each byte, so a stale address is never answered
   // Idle data flips every cycle so a read outside valid shows up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rsp  <= '0;
         wait_cnt <= 4'h0;
      end else if (mem_req.rd && !mem_rsp.valid && wait_cnt >= dly) begin
         mem_rsp.valid <= 1'b1;
         mem_rsp.data  <= mem_req.addr[7:0] ^ 8'h5a;
         wait_cnt      <= 4'h0;
      end else begin
         mem_rsp.valid <= 1'b0;
         mem_rsp.data  <= ~mem_rsp.data;
         wait_cnt      <= mem_req.rd ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// *** verif/btag_top_bench.sv ***
`timescale 1ns/1ps
module btag_top_bench;
   import btag_pkg::*;
   logic          sys_clk = 1'b0;
   logic          rst_n   = 1'b0;
   btag_req_t     req     = '0;
   logic [15:0]   pv [4]  = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
   logic          bank_wr = 1'b0;
   logic [7:0]    bank_wdata = 8'h00;
   logic [3:0]    dly     = 4'h0;
   logic          ready, pc_load, bad_req;
   logic [7:0]    bank_rdata;
   logic [19:0]   pc;
   btag_mem_req_t mem_req;
   btag_mem_rsp_t mem_rsp;
   int            error_cnt = 0;
   int            n_checks  = 0;

   always #5 sys_clk = ~sys_clk;

   btag_top u_btag_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ(req), .REQ_READY(ready),
      .ACCUM_PAIR(pv[0]), .SECOND_PAIR(pv[1]), .THIRD_PAIR(pv[2]), .FOURTH_PAIR(pv[3]),
      .BANK_WR(bank_wr), .BANK_WDATA(bank_wdata), .BANK_RDATA(bank_rdata),
      .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .PC_LOAD(pc_load),
      .PROGRAM_COUNTER(pc), .BAD_REQ(bad_req));

   btag_fetch_model u_btag_fetch_model (.clk(sys_clk), .rst_n(rst_n), .dly(dly),
      .mem_req(mem_req), .mem_rsp(mem_rsp));

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // f = {is_jump, is_branch, is_table_call}; exp is the counter after the answer
   task automatic issue(input btag_mode_t m, input logic [2:0] f, input logic [19:0] npc,
                        input logic [19:0] imm, input logic [4:0] idx, input btag_pair_t p,
                        input logic ok, input logic [19:0] exp);
      int n;
      n = 0;
      @(negedge sys_clk);
      req <= '{1'b1, m, f[2], f[1], f[0], npc, imm, idx, p};
      @(negedge sys_clk);
      chk({19'h0, ready}, {19'h0, !(ok && (m == BTAG_TABLE))});
      req.valid <= 1'b0;
      while (pc_load !== 1'b1 && bad_req !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      chk({19'h0, pc_load}, {19'h0, ok});
      chk({19'h0, bad_req}, {19'h0, !ok});
      chk(pc, exp);
   endtask

   function automatic logic [19:0] tbl_pc(input logic [4:0] i);
      logic [7:0] a;
      a = 8'h80 + {2'b00, i, 1'b0};
      // Low byte sits at the even address, high byte at the next one
      return {4'h0, (a + 8'h01) ^ 8'h5a, a[7:0] ^ 8'h5a};
   endfunction

   task automatic t_bank();
      chk(pc, 20'h00000);
      chk({19'h0, ready}, 20'h00001);
      chk({12'h0, bank_rdata}, 20'h00000);
      @(negedge sys_clk);
      bank_wr    <= 1'b1;
      bank_wdata <= 8'hfa;
      @(negedge sys_clk);
      bank_wr    <= 1'b0;
      @(negedge sys_clk);
      chk({12'h0, bank_rdata}, 20'h0000a);
   endtask

   task automatic t_rel();
      issue(BTAG_REL8, 3'b010, 20'h00100, 20'hfff80, 5'h0, BTAG_ACCUM, 1, 20'h00080);
      issue(BTAG_REL8, 3'b110, 20'hffff0, 20'h0007f, 5'h0, BTAG_ACCUM, 1, 20'h0006f);
      issue(BTAG_REL16, 3'b010, 20'h10000, 20'h08000, 5'h0, BTAG_ACCUM, 1, 20'h08000);
      issue(BTAG_REL16, 3'b010, 20'h12345, 20'h07fff, 5'h0, BTAG_ACCUM, 1, 20'h1a344);
      issue(BTAG_REL8, 3'b000, 20'h00100, 20'h00010, 5'h0, BTAG_ACCUM, 0, 20'h1a344);
      issue(BTAG_REL16, 3'b011, 20'h00100, 20'h00010, 5'h0, BTAG_ACCUM, 0, 20'h1a344);
   endtask

   task automatic t_imm();
      issue(BTAG_IMM20, 3'b000, 20'h0, 20'habcde, 5'h0, BTAG_ACCUM, 1, 20'habcde);
      issue(BTAG_IMM16, 3'b100, 20'h0, 20'hf1234, 5'h0, BTAG_ACCUM, 1, 20'h01234);
      issue(BTAG_NONE, 3'b000, 20'h0, 20'h55555, 5'h0, BTAG_ACCUM, 0, 20'h01234);
   endtask

   task automatic t_tbl();
      issue(BTAG_TABLE, 3'b001, 20'h0, 20'hfffff, 5'h00, BTAG_ACCUM, 1, tbl_pc(5'h00));
      dly = 4'h3;
      issue(BTAG_TABLE, 3'b001, 20'h0, 20'h0, 5'h1f, BTAG_ACCUM, 1, tbl_pc(5'h1f));
      issue(BTAG_TABLE, 3'b001, 20'h0, 20'h0, 5'h0a, BTAG_ACCUM, 1, tbl_pc(5'h0a));
      dly = 4'h0;
      issue(BTAG_TABLE, 3'b000, 20'h0, 20'h0, 5'h01, BTAG_ACCUM, 0, tbl_pc(5'h0a));
      issue(BTAG_IMM20, 3'b001, 20'h0, 20'h12345, 5'h01, BTAG_ACCUM, 0, tbl_pc(5'h0a));
   endtask

   task automatic t_reg();
      for (int i = 0; i < 4; i++) begin
         issue(BTAG_REGDIR, 3'b000, 20'h0, 20'h0, 5'h0, btag_pair_t'(i), 1, {4'ha, pv[i]});
      end
      issue(BTAG_REGDIR, 3'b100, 20'h0, 20'h0, 5'h0, BTAG_ACCUM, 1, {4'ha, pv[0]});
      issue(BTAG_REGDIR, 3'b100, 20'h0, 20'h0, 5'h0, BTAG_FOURTH, 0, {4'ha, pv[0]});
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      t_bank();
      t_rel();
      t_imm();
      t_tbl();
      t_reg();
      summarize();
   end

   // Whole run is well under a thousand cycles
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule
